// [verilog/flag_shift_skip_pkg.sv]
// Purpose: Shared constants for the flag, shift and skip instruction group.
// Assumes: 16-bit instruction words, 128 x 4-bit data memory, 11-bit program counter.
// Notes on behaviour
// [RULE_01] The set-carry opcode forces the carry flag to 1 in one cycle and changes nothing else. The code also steps the program counter by 1.
// [RULE_02] The parameter-flag opcode stores a 4-bit immediate in one cycle; bit 3 set picks oscillator/16384.
// [RULE_03] Immediate bits 0 to 2 of the parameter-flag opcode are stored but drive nothing.
// [RULE_04] Shift and skip opcodes address one data nibble with the low seven opcode bits.
// [RULE_05] Shift-left moves bits up, fills bit 0 with 0, puts old bit 3 in carry, writes memory and accumulator.
// [RULE_06] Shift-right moves bits down, fills bit 3 with 0, puts old bit 0 in carry, writes memory and accumulator.
// [RULE_07] Skip-on-bit-0 adds 2 to the program counter when nibble bit 0 is 1, else adds 1, in one cycle.
// [RULE_08] Skip-on-bit-1 adds 2 to the program counter when nibble bit 1 is 1, else adds 1, in one cycle.
// [RULE_09] Both shifts set the zero flag from a zero result; skips leave both flags alone.
package flag_shift_skip_pkg;

   localparam int INSTR_W   = 16;
   localparam int NIBBLE_W  = 4;
   localparam int ADDR_W    = 7;
   localparam int PC_W      = 11;
   localparam int OPC9_W    = 9;
   localparam int OPC12_W   = 12;
   localparam int OPC9_LSB  = 7;
   localparam int OPC12_LSB = 4;

   // Nine-bit opcode prefixes, instruction bits 15..7
   localparam logic [OPC9_W-1:0] OPC_SET_CARRY   = 9'h0a0;  // 0 1010 0000
   localparam logic [OPC9_W-1:0] OPC_SHIFT_LEFT  = 9'h098;  // 0 1001 1000
   localparam logic [OPC9_W-1:0] OPC_SHIFT_RIGHT = 9'h09a;  // 0 1001 1010
   localparam logic [OPC9_W-1:0] OPC_SKIP_BIT0   = 9'h110;  // 1 0001 0000
   localparam logic [OPC9_W-1:0] OPC_SKIP_BIT1   = 9'h111;  // 1 0001 0001
   // Twelve-bit prefix of the parameter-flag opcode, bits 15..4
   localparam logic [OPC12_W-1:0] OPC_WRITE_PARAM = 12'h160;

   // Parameter flag field layout
   localparam int PARAM_WDT_SEL_BIT = 3;

   // Reset values
   localparam logic [NIBBLE_W-1:0] ACCUM_RESET = 4'h0;
   localparam logic [NIBBLE_W-1:0] PARAM_RESET = 4'h0;
   localparam logic [PC_W-1:0]     PC_RESET    = 11'h000;
   localparam logic                CARRY_RESET = 1'b0;
   localparam logic                ZERO_RESET  = 1'b0;

   // Program counter steps
   localparam logic [PC_W-1:0] PC_STEP_NEXT = 11'h001;
   localparam logic [PC_W-1:0] PC_STEP_SKIP = 11'h002;

   // Watchdog input clock dividers, in oscillator cycles
   localparam int WDT_SLOW_DIV = 16384;
   localparam int WDT_FAST_DIV = 1024;

endpackage

// [verilog/nibble_shifter.sv]
// Purpose: Zero-fill one-place shifter for a 4-bit nibble.
// Assumes: Purely combinational, used by the instruction executor.
// Notes: Carry out is the bit pushed off the end.
`timescale 1ns/1ns
module nibble_shifter
   import flag_shift_skip_pkg::*;
(
   // Operand and direction
   input  wire logic [NIBBLE_W-1:0] operand,
   input  wire logic                shift_right,
   // Result
   output logic      [NIBBLE_W-1:0] result,
   output logic                     carry_out,
   output logic                     result_zero
);

   // Shift with zero fill on the vacated end
   always_comb begin
      if (shift_right) begin
         // [RULE_06] Right, zero fill
         result    = {1'b0, operand[NIBBLE_W-1:1]};
         carry_out = operand[0];
      end else begin
         // [RULE_05] Left, zero fill
         result    = {operand[NIBBLE_W-2:0], 1'b0};
         carry_out = operand[NIBBLE_W-1];
      end
      // [RULE_09] Zero from result
      result_zero = (result == 4'h0);
   end

endmodule

// [verilog/flag_shift_skip_ops.sv]
// Purpose: Executes set-carry, parameter-flag, shift and bit-skip instructions.
// Assumes: One instruction per clock when instr_valid is high; clock is the oscillator.
// Notes: Data memory lives here as flip-flops with a side port for loading and viewing.
`timescale 1ns/1ns
module flag_shift_skip_ops
   import flag_shift_skip_pkg::*;
#(
   parameter int SLOW_DIV = WDT_SLOW_DIV,
   parameter int FAST_DIV = WDT_FAST_DIV,
   parameter int MEM_DEPTH = 128
)(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                sys_rst,
   // Instruction stream
   input  wire logic                instr_valid,
   input  wire logic [INSTR_W-1:0]  instr_word,
   // Side port into data memory
   input  wire logic                mem_load_en,
   input  wire logic [ADDR_W-1:0]   mem_load_addr,
   input  wire logic [NIBBLE_W-1:0] mem_load_data,
   input  wire logic [ADDR_W-1:0]   mem_view_addr,
   output logic      [NIBBLE_W-1:0] mem_view_data,
   // Core state
   output logic      [NIBBLE_W-1:0] accumulator,
   output logic                     carry_flag,
   output logic                     zero_flag,
   output logic      [PC_W-1:0]     program_counter,
   output logic      [NIBBLE_W-1:0] parameter_flag_field,
   // Watchdog input clock enable
   output logic                     wdt_tick
);

   localparam int DIV_W = $clog2(SLOW_DIV);

   // Counter step for every executed instruction; a skip steps over one word.
   // Wraps at the counter width, so a skip near the top lands at a low address.
   function automatic logic [PC_W-1:0] counter_step(input logic [PC_W-1:0] count, input logic skip);
      if (skip) begin
         return count + PC_STEP_SKIP;
      end
      return count + PC_STEP_NEXT;
   endfunction

   // Decoded instruction fields
   logic [OPC9_W-1:0]   opc9;
   logic [OPC12_W-1:0]  opc12;
   logic [ADDR_W-1:0]   data_addr;
   logic [NIBBLE_W-1:0] immediate;
   logic                is_set_carry;
   logic                is_write_param;
   logic                is_shift_left;
   logic                is_shift_right;
   logic                is_skip_bit0;
   logic                is_skip_bit1;

   // Data memory and its write request
   logic [NIBBLE_W-1:0] mem [MEM_DEPTH];
   logic [NIBBLE_W-1:0] operand;
   logic                mem_wr_en;
   logic [ADDR_W-1:0]   mem_wr_addr;
   logic [NIBBLE_W-1:0] mem_wr_data;

   // Shifter outputs
   logic [NIBBLE_W-1:0] shift_result;
   logic                shift_carry;
   logic                shift_zero;

   // Next state of the core registers
   logic [NIBBLE_W-1:0] next_accumulator;
   logic                next_carry_flag;
   logic                next_zero_flag;
   logic [PC_W-1:0]     next_program_counter;
   logic [NIBBLE_W-1:0] next_parameter_flag_field;

   // Watchdog divider
   logic [DIV_W-1:0]    div_count;
   logic [DIV_W-1:0]    next_div_count;
   logic [DIV_W-1:0]    div_last;
   logic                next_wdt_tick;

   // Field split of the instruction word
   always_comb begin
      opc9      = instr_word[INSTR_W-1:OPC9_LSB];
      opc12     = instr_word[INSTR_W-1:OPC12_LSB];
      // [RULE_04] Low seven bits address
      data_addr = instr_word[ADDR_W-1:0];
      immediate = instr_word[NIBBLE_W-1:0];
   end

   // Opcode match, gated by a valid instruction
   always_comb begin
      is_set_carry   = instr_valid && (opc9 == OPC_SET_CARRY);
      is_write_param = instr_valid && (opc12 == OPC_WRITE_PARAM);
      is_shift_left  = instr_valid && (opc9 == OPC_SHIFT_LEFT);
      is_shift_right = instr_valid && (opc9 == OPC_SHIFT_RIGHT);
      is_skip_bit0   = instr_valid && (opc9 == OPC_SKIP_BIT0);
      is_skip_bit1   = instr_valid && (opc9 == OPC_SKIP_BIT1);
   end

   // Operand fetch is a plain index into the flop array
   assign operand = mem[data_addr];

   nibble_shifter shifter (
      .operand     (operand),
      .shift_right (is_shift_right),
      .result      (shift_result),
      .carry_out   (shift_carry),
      .result_zero (shift_zero)
   );

   // Next values of the core registers
   always_comb begin
      next_accumulator          = accumulator;
      next_carry_flag           = carry_flag;
      next_zero_flag            = zero_flag;
      next_program_counter      = program_counter;
      next_parameter_flag_field = parameter_flag_field;
      if (instr_valid) begin
         // Every executed instruction steps the counter at least once
         next_program_counter = counter_step(program_counter, 1'b0);
      end
      if (is_set_carry) begin
         // [RULE_01] Carry forced high
         next_carry_flag = 1'b1;
      end
      if (is_write_param) begin
         // [RULE_02] Store immediate
         // [RULE_03] Low bits kept, unused
         next_parameter_flag_field = immediate;
      end
      if (is_shift_left || is_shift_right) begin
         // [RULE_05] Result into accumulator
         // [RULE_06] Result into accumulator
         next_accumulator = shift_result;
         next_carry_flag  = shift_carry;
         // [RULE_09] Zero flag update
         next_zero_flag   = shift_zero;
      end
      if (is_skip_bit0 && operand[0]) begin
         // [RULE_07] Skip on bit 0
         next_program_counter = counter_step(program_counter, 1'b1);
      end
      if (is_skip_bit1 && operand[1]) begin
         // [RULE_08] Skip on bit 1
         next_program_counter = counter_step(program_counter, 1'b1);
      end
   end

   // Core registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         accumulator          <= ACCUM_RESET;
         carry_flag           <= CARRY_RESET;
         zero_flag            <= ZERO_RESET;
         program_counter      <= PC_RESET;
         parameter_flag_field <= PARAM_RESET;
      end else begin
         accumulator          <= next_accumulator;
         carry_flag           <= next_carry_flag;
         zero_flag            <= next_zero_flag;
         program_counter      <= next_program_counter;
         parameter_flag_field <= next_parameter_flag_field;
      end
   end

   // Memory write request; a shift beats the side port on a clash
   always_comb begin
      mem_wr_en   = 1'b0;
      mem_wr_addr = mem_load_addr;
      mem_wr_data = mem_load_data;
      if (is_shift_left || is_shift_right) begin
         // [RULE_05] Result into memory
         // [RULE_06] Result into memory
         mem_wr_en   = 1'b1;
         mem_wr_addr = data_addr;
         mem_wr_data = shift_result;
      end else if (mem_load_en) begin
         mem_wr_en = 1'b1;
      end
   end

   // Data memory has no reset, as a real RAM would not
   always_ff @(posedge clock) begin
      if (mem_wr_en) begin
         mem[mem_wr_addr] <= mem_wr_data;
      end
   end

   assign mem_view_data = mem[mem_view_addr];

   // Divider end point follows the watchdog select bit
   always_comb begin
      // [RULE_02] Select oscillator/16384
      if (parameter_flag_field[PARAM_WDT_SEL_BIT]) begin
         div_last = DIV_W'(SLOW_DIV - 1);
      end else begin
         div_last = DIV_W'(FAST_DIV - 1);
      end
   end

   // Next divider count; wraps early if the end point shrinks past it
   always_comb begin
      next_wdt_tick  = 1'b0;
      next_div_count = div_count + DIV_W'(1);
      if (div_count >= div_last) begin
         next_wdt_tick  = 1'b1;
         next_div_count = '0;
      end
   end

   // Divider registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         div_count <= '0;
         wdt_tick  <= 1'b0;
      end else begin
         div_count <= next_div_count;
         wdt_tick  <= next_wdt_tick;
      end
   end

endmodule

// [verif/flag_shift_skip_sva.sv]
// Purpose: Port checks of the flag, shift and skip executor.
// Assumes: Bench views the nibble that a shift or skip names.
// Notes: Memory is seen only through the view port.
`timescale 1ns/1ns
module flag_shift_skip_sva
   import flag_shift_skip_pkg::*;
(
   // Clock, reset, instruction
   input wire logic                clock,
   input wire logic                sys_rst,
   input wire logic                instr_valid,
   input wire logic [INSTR_W-1:0]  instr_word,
   // State at the ports
   input wire logic [ADDR_W-1:0]   mem_view_addr,
   input wire logic [NIBBLE_W-1:0] mem_view_data,
   input wire logic [NIBBLE_W-1:0] accumulator,
   input wire logic                carry_flag,
   input wire logic                zero_flag,
   input wire logic [PC_W-1:0]     program_counter,
   input wire logic [NIBBLE_W-1:0] parameter_flag_field
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Prefix is zero when idle, so no opcode matches then
   logic [OPC9_W-1:0] op;
   logic              seen;
   assign op   = instr_valid ? instr_word[15:7] : '0;
   assign seen = mem_view_addr == instr_word[6:0];
   chk_set_carry_only:
      assert property (op == OPC_SET_CARRY |=> carry_flag && $stable({zero_flag, accumulator}))
      else $error("set carry disturbed state");
   chk_param_store:
      assert property (instr_valid && instr_word[15:4] == OPC_WRITE_PARAM
         |=> parameter_flag_field == $past(instr_word[NIBBLE_W-1:0])) else $error("param field wrong");
   chk_shift_left:
      assert property (op == OPC_SHIFT_LEFT && seen |=> {carry_flag, accumulator} == {$past(mem_view_data), 1'h0})
      else $error("left shift wrong");
   chk_shift_right:
      assert property (op == OPC_SHIFT_RIGHT && seen |=> {accumulator, carry_flag} == {1'h0, $past(mem_view_data)})
      else $error("right shift wrong");
   chk_shift_zero:
      assert property (op == OPC_SHIFT_LEFT || op == OPC_SHIFT_RIGHT |=> zero_flag == (accumulator == 4'h0))
      else $error("zero flag wrong");
   chk_skip_bit0:
      assert property (op == OPC_SKIP_BIT0 && seen |=> program_counter == $past(program_counter)
         + ($past(mem_view_data[0]) ? PC_STEP_SKIP : PC_STEP_NEXT)) else $error("bit 0 skip wrong");
   chk_skip_bit1:
      assert property (op == OPC_SKIP_BIT1 && seen |=> program_counter == $past(program_counter)
         + ($past(mem_view_data[1]) ? PC_STEP_SKIP : PC_STEP_NEXT)) else $error("bit 1 skip wrong");
   chk_skip_keeps_flags:
      assert property (op == OPC_SKIP_BIT0 || op == OPC_SKIP_BIT1 |=> $stable({carry_flag, zero_flag, accumulator}))
      else $error("skip changed state");
   // Main scenarios reached
   cover property (op == OPC_SHIFT_RIGHT && seen);
   cover property (op == OPC_SKIP_BIT1 && seen && mem_view_data[1]);
   cover property (instr_valid && instr_word[15:4] == OPC_WRITE_PARAM && instr_word[3]);
endmodule

bind flag_shift_skip_ops flag_shift_skip_sva chk (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
   .instr_word(instr_word), .mem_view_addr(mem_view_addr), .mem_view_data(mem_view_data), .accumulator(accumulator),
   .carry_flag(carry_flag), .zero_flag(zero_flag), .program_counter(program_counter),
   .parameter_flag_field(parameter_flag_field));

// [verif/testbench.sv]
// Purpose: Self-checking bench for the flag, shift and skip executor.
// Assumes: Short divider counts keep tick checks brief.
// Notes: Each row preloads a nibble, runs one opcode, checks state.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module testbench
   import flag_shift_skip_pkg::*;
;
   localparam int SLOW = 16;
   localparam int FAST = 4;
   typedef struct packed {
      logic [INSTR_W-1:0]  iw;
      logic [NIBBLE_W-1:0] mem;
      logic [NIBBLE_W-1:0] accum;
      logic                carry;
      logic                zero;
      logic [1:0]          step;
   } row_type;
   // Word, preload, then accumulator, carry, zero and pc step
   localparam row_type ROWS [10] = '{
      '{16'h4c7f, 4'h9, 4'h2, 1'h1, 1'h0, 2'h1}, '{16'h8805, 4'h1, 4'h2, 1'h1, 1'h0, 2'h2},
      '{16'h4d00, 4'h1, 4'h0, 1'h1, 1'h1, 2'h1}, '{16'h88a2, 4'hd, 4'h0, 1'h1, 1'h1, 2'h1},
      '{16'h4c40, 4'h6, 4'hc, 1'h0, 1'h0, 2'h1}, '{16'h8891, 4'h2, 4'hc, 1'h0, 1'h0, 2'h2},
      '{16'h8812, 4'he, 4'hc, 1'h0, 1'h0, 2'h1}, '{16'h4d33, 4'h8, 4'h4, 1'h0, 1'h0, 2'h1},
      '{16'h507f, 4'h5, 4'h4, 1'h1, 1'h0, 2'h1}, '{16'h4c01, 4'h8, 4'h0, 1'h1, 1'h1, 2'h1}};
   logic                clock = 1'h0;
   logic                sys_rst = 1'h1;
   logic                instr_valid = 1'h0;
   logic [INSTR_W-1:0]  instr_word = '0;
   logic                mem_load_en = 1'h0;
   logic [ADDR_W-1:0]   mem_load_addr = '0;
   logic [NIBBLE_W-1:0] mem_load_data = '0;
   logic [ADDR_W-1:0]   mem_view_addr = '0;
   logic [NIBBLE_W-1:0] mem_view_data;
   logic [NIBBLE_W-1:0] accumulator;
   logic                carry_flag;
   logic                zero_flag;
   logic [PC_W-1:0]     program_counter;
   logic [NIBBLE_W-1:0] parameter_flag_field;
   logic                wdt_tick;
   logic [PC_W-1:0]     pc0;
   row_type             r;
   int                  err_total = 0;
   int                  n_compared = 0;
   int                  cycles = 0;
   int                  g;

   flag_shift_skip_ops #(.SLOW_DIV(SLOW), .FAST_DIV(FAST)) uut (.clock(clock), .sys_rst(sys_rst),
      .instr_valid(instr_valid), .instr_word(instr_word), .mem_load_en(mem_load_en), .mem_load_addr(mem_load_addr),
      .mem_load_data(mem_load_data), .mem_view_addr(mem_view_addr), .mem_view_data(mem_view_data),
      .accumulator(accumulator), .carry_flag(carry_flag), .zero_flag(zero_flag), .program_counter(program_counter),
      .parameter_flag_field(parameter_flag_field), .wdt_tick(wdt_tick));

   always #20 clock = ~clock;

   // Hang guard, well above the roughly 90 cycles needed
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Preload a nibble and point the view port at it
   task automatic load(input logic [ADDR_W-1:0] a, input logic [NIBBLE_W-1:0] d);
      @(posedge clock);
      mem_load_en <= 1'h1;
      mem_load_addr <= a;
      mem_load_data <= d;
      mem_view_addr <= a;
      @(posedge clock);
      mem_load_en <= 1'h0;
   endtask

   task automatic write_params(input logic [NIBBLE_W-1:0] imm);
      @(posedge clock);
      instr_valid <= 1'h1;
      instr_word <= {OPC_WRITE_PARAM, imm};
      @(posedge clock);
      instr_valid <= 1'h0;
      #1 `CHK("param field", imm, parameter_flag_field)
   endtask

   // Cycles between two ticks; the first wait skips a partial period
   task automatic tick_gap(output int n);
      n = 0;
      repeat (40) begin @(posedge clock); #1 if (wdt_tick === 1'h1) break; end
      repeat (40) begin @(posedge clock); n++; #1 if (wdt_tick === 1'h1) break; end
   endtask

   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'h0;
      #1 `CHK("reset", {22'h0}, {accumulator, carry_flag, zero_flag, program_counter, parameter_flag_field, wdt_tick})
      foreach (ROWS[i]) begin
         r = ROWS[i];
         load(r.iw[6:0], r.mem);
         instr_valid <= 1'h1;
         instr_word <= r.iw;
         #1 pc0 = program_counter;
         @(posedge clock);
         instr_valid <= 1'h0;
         #1 `CHK("accum carry", {r.accum, r.carry}, {accumulator, carry_flag})
         `CHK("zero", r.zero, zero_flag)
         `CHK("memory", (r.iw[15:9] == 7'h26) ? r.accum : r.mem, mem_view_data)
         `CHK("pc step", pc0 + {9'h000, r.step}, program_counter)
      end
      // Back to back shifts, second reads the first one's result
      load(7'h03, 4'h9);
      instr_valid <= 1'h1;
      instr_word <= {OPC_SHIFT_LEFT, 7'h03};
      #1 pc0 = program_counter;
      @(posedge clock);
      instr_word <= {OPC_SHIFT_RIGHT, 7'h03};
      @(posedge clock);
      instr_valid <= 1'h0;
      #1 `CHK("b2b state", 9'h021, {accumulator, carry_flag, mem_view_data})
      `CHK("b2b pc", pc0 + 11'h002, program_counter)
      // Side-port write to the nibble that a shift names loses to the shift
      @(posedge clock);
      instr_valid <= 1'h1;
      instr_word <= {OPC_SHIFT_LEFT, 7'h03};
      mem_load_en <= 1'h1;
      mem_load_addr <= 7'h03;
      mem_load_data <= 4'hf;
      @(posedge clock);
      instr_valid <= 1'h0;
      mem_load_en <= 1'h0;
      #1 `CHK("clash", 8'h22, {accumulator, mem_view_data})
      write_params(4'h7);
      tick_gap(g);
      `CHK("fast gap", FAST, g)
      write_params(4'h8);
      tick_gap(g);
      `CHK("slow gap", SLOW, g)
      // Reset in mid-run, with an instruction waiting at the first edge after release
      @(posedge clock);
      sys_rst <= 1'h1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'h0;
      instr_valid <= 1'h1;
      instr_word <= {OPC_SET_CARRY, 7'h00};
      #1 `CHK("rst2", {22'h0}, {accumulator, carry_flag, zero_flag, program_counter, parameter_flag_field, wdt_tick})
      @(posedge clock);
      instr_valid <= 1'h0;
      #1 `CHK("after reset", 12'h801, {carry_flag, program_counter})
      wrap_up();
   end
endmodule
